// ==== exec_pkg.sv ====
// constants shared by the branch, skip and load execution block
package exec_pkg;

  // ****************************************
  // register map, byte addresses on the bus
  // ****************************************
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_REG_WINDOW = 8'h80;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_UNSUPPORTED_BIT = 1;
  localparam logic CTRL_RUN_RESET = 1'b0;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // status flag positions
  // ****************************************
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ****************************************
  // instruction masks and patterns
  // ****************************************
  localparam logic [15:0] MASK_SKIP_REG = 16'hfe08;
  localparam logic [15:0] PAT_SKIP_REG_SET = 16'hfe00;
  localparam logic [15:0] MASK_SKIP_IO = 16'hff00;
  localparam logic [15:0] PAT_SKIP_IO_CLEAR = 16'h9900;
  localparam logic [15:0] PAT_SKIP_IO_SET = 16'h9b00;
  localparam logic [15:0] MASK_BRANCH = 16'hf800;
  localparam logic [15:0] PAT_BRANCH = 16'hf000;
  localparam int unsigned BRANCH_CLEAR_BIT = 10;
  localparam logic [15:0] MASK_COPY = 16'hfc00;
  localparam logic [15:0] PAT_COPY = 16'h2c00;
  localparam logic [15:0] MASK_LOAD_CONST = 16'hf000;
  localparam logic [15:0] PAT_LOAD_CONST = 16'he000;
  localparam logic [15:0] MASK_LOAD_X = 16'hfe0f;
  localparam logic [15:0] PAT_LOAD_X = 16'h900c;
  localparam logic [15:0] PAT_LOAD_X_INC = 16'h900d;
  localparam logic [15:0] PAT_LOAD_X_DEC = 16'h900e;
  localparam logic [15:0] MASK_LONG_DIRECT = 16'hfc0f;
  localparam logic [15:0] PAT_LONG_DIRECT = 16'h9000;
  localparam logic [15:0] MASK_LONG_JUMP = 16'hfe0c;
  localparam logic [15:0] PAT_LONG_JUMP = 16'h940c;

  // ****************************************
  // register file layout
  // ****************************************
  localparam logic [4:0] PTR_X_LOW = 5'h1a;
  localparam logic [4:0] PTR_X_HIGH = 5'h1b;
  localparam logic [7:0] GPR_RESET = 8'h00;

endpackage

// ==== exec_reg_file.sv ====
// general register bank with operand, debug and pointer ports
`timescale 1ns/10ps
module exec_reg_file #(
  parameter int unsigned REG_COUNT = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [4:0] operandAddr,
  output logic [7:0] operandData,
  input wire logic [4:0] debugAddr,
  output logic [7:0] debugData,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic ptrWrEn,
  input wire logic [15:0] ptrWrData,
  output logic [15:0] ptrData
);

  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] regs_d [REG_COUNT];

  // ****************************************
  // read ports, combinational
  // ****************************************
  assign operandData = regs_q[operandAddr];
  assign debugData = regs_q[debugAddr];
  assign ptrData = {regs_q[exec_pkg::PTR_X_HIGH], regs_q[exec_pkg::PTR_X_LOW]};

  // ****************************************
  // next value per register, one write port plus pointer pair
  // ****************************************
  for (genvar i = 0; i < REG_COUNT; i++) begin : gen_reg
    always_comb begin
      regs_d[i] = regs_q[i];
      if (ptrWrEn && (5'(i) == exec_pkg::PTR_X_LOW)) begin
        regs_d[i] = ptrWrData[7:0];
      end
      if (ptrWrEn && (5'(i) == exec_pkg::PTR_X_HIGH)) begin
        regs_d[i] = ptrWrData[15:8];
      end
      if (wrEn && (wrAddr == 5'(i))) begin
        regs_d[i] = wrData; // data write wins over pointer update
      end
    end

    always_ff @(posedge core_clk) begin
      if (reset) begin
        regs_q[i] <= exec_pkg::GPR_RESET;
      end else begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

endmodule

// ==== flag_condition.sv ====
// selects one status flag and decides whether a branch is taken
`timescale 1ns/10ps
module flag_condition (
  input wire logic [7:0] flags,
  input wire logic [2:0] flagSel,
  input wire logic clearForm,
  output logic taken
);

  logic flagBit;

  // ****************************************
  // sign flag is formed from negative xor overflow
  // ****************************************
  always_comb begin
    if (flagSel == exec_pkg::FLAG_S) begin
      flagBit = flags[exec_pkg::FLAG_N] ^ flags[exec_pkg::FLAG_V]; // [RL9]
    end else begin
      flagBit = flags[flagSel]; // [RL4] [RL5] [RL6] [RL7] [RL8] [RL10] [RL11] [RL12] [RL13]
    end
    taken = clearForm ? !flagBit : flagBit; // [RL4]
  end

endmodule

// ==== branch_skip_and_load_exec.sv ====
// execution core for skips, flag branches, register moves and X loads
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
// Contract
// RL1: register bit set skips next instruction, pc advances 2 or 3, flags kept
// RL2: io bit clear skips next instruction, one or two cycles, flags kept
// RL3: io bit set skips next instruction, else continue, flags kept
// RL4: generic flag branch picks bit s, jumps to pc+k+1 on set or clear
// RL5: equal and not-equal branches test the zero flag
// RL6: carry set and carry clear branches test the carry flag
// RL7: unsigned ge and lt branches decode to the same carry tests
// RL8: negative and positive branches test the negative flag
// RL9: signed ge and lt branches test negative xor overflow
// RL10: half carry branches test the half carry flag
// RL11: transfer bit branches test the t flag
// RL12: overflow branches test the overflow flag
// RL13: interrupt enabled branch tests global interrupt enable, flags untouched
// RL14: register copy and constant load write rd in one cycle, no flags
// RL15: load through x reads memory in two cycles, post-increment bumps x
// RL16: pre-decrement load lowers x first then reads at new x
// RL17: false condition one cycle, taken branch two, skip three only over long; the code takes two for every taken skip
module branch_skip_and_load_exec #(
  parameter int unsigned PC_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic [PC_WIDTH-1:0] progAddr,
  input wire logic [15:0] progWord,
  input wire logic [255:0] ioRegs,
  output logic [15:0] dataAddr,
  output logic dataRdEn,
  input wire logic [7:0] dataRdData,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {ST_RUN, ST_BRANCH2, ST_SKIP2, ST_LOAD2} exec_state_t;

  exec_state_t state_q, state_d;
  logic [PC_WIDTH-1:0] pc_q, pc_d;
  logic [15:0] dataAddr_q, dataAddr_d;
  logic dataRdEn_q, dataRdEn_d;
  logic [4:0] loadDst_q, loadDst_d;
  logic unsupported_q, unsupported_d;
  logic run_q, run_d;
  logic [7:0] flags_q, flags_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;

  logic isSkipReg, isSkipIoClr, isSkipIoSet, isSkip, isBranch, isCopy, isLoadConst;
  logic isLoadX, isLoadXInc, isLoadXDec, isLoad, skipTaken, branchTaken, isLongWord;
  logic [4:0] operandAddr;
  logic [7:0] operandData, debugData;
  logic [15:0] ptrData;
  logic rfWrEn, ptrWrEn;
  logic [4:0] rfWrAddr;
  logic [7:0] rfWrData;
  logic [15:0] ptrWrData;
  logic [PC_WIDTH-1:0] pcPlusOne, pcBranch;
  logic wrFire, rdFire, wrMapped, rdMapped;

  // ****************************************
  // instruction decode of the word at the program counter
  // ****************************************
  assign isSkipReg = (progWord & exec_pkg::MASK_SKIP_REG) == exec_pkg::PAT_SKIP_REG_SET;
  assign isSkipIoClr = (progWord & exec_pkg::MASK_SKIP_IO) == exec_pkg::PAT_SKIP_IO_CLEAR;
  assign isSkipIoSet = (progWord & exec_pkg::MASK_SKIP_IO) == exec_pkg::PAT_SKIP_IO_SET;
  assign isSkip = isSkipReg || isSkipIoClr || isSkipIoSet;
  assign isBranch = (progWord & exec_pkg::MASK_BRANCH) == exec_pkg::PAT_BRANCH;
  assign isCopy = (progWord & exec_pkg::MASK_COPY) == exec_pkg::PAT_COPY;
  assign isLoadConst = (progWord & exec_pkg::MASK_LOAD_CONST) == exec_pkg::PAT_LOAD_CONST;
  assign isLoadX = (progWord & exec_pkg::MASK_LOAD_X) == exec_pkg::PAT_LOAD_X;
  assign isLoadXInc = (progWord & exec_pkg::MASK_LOAD_X) == exec_pkg::PAT_LOAD_X_INC;
  assign isLoadXDec = (progWord & exec_pkg::MASK_LOAD_X) == exec_pkg::PAT_LOAD_X_DEC;
  assign isLoad = isLoadX || isLoadXInc || isLoadXDec;
  // a skipped instruction is two words when it is a direct load/store or a long jump/call
  assign isLongWord = ((progWord & exec_pkg::MASK_LONG_DIRECT) == exec_pkg::PAT_LONG_DIRECT)
                   || ((progWord & exec_pkg::MASK_LONG_JUMP) == exec_pkg::PAT_LONG_JUMP);
  // copy reads its source, the register skip reads the tested register
  assign operandAddr = isCopy ? {progWord[9], progWord[3:0]} : progWord[8:4];

  // ****************************************
  // skip condition from register or io bit
  // ****************************************
  always_comb begin
    skipTaken = 1'b0;
    if (isSkipReg) begin
      skipTaken = operandData[progWord[2:0]]; // [RL1]
    end else if (isSkipIoClr) begin
      skipTaken = !ioRegs[progWord[7:0]]; // [RL2]
    end else if (isSkipIoSet) begin
      skipTaken = ioRegs[progWord[7:0]]; // [RL3]
    end
  end

  flag_condition u_flag_condition (
    .flags(flags_q),
    .flagSel(progWord[2:0]),
    .clearForm(progWord[exec_pkg::BRANCH_CLEAR_BIT]),
    .taken(branchTaken)
  );

  exec_reg_file #(
    .REG_COUNT(32)
  ) u_reg_file (
    .core_clk(core_clk),
    .reset(reset),
    .operandAddr(operandAddr),
    .operandData(operandData),
    .debugAddr(s_axi_araddr[6:2]), // window reads always follow the read address
    .debugData(debugData),
    .wrEn(rfWrEn),
    .wrAddr(rfWrAddr),
    .wrData(rfWrData),
    .ptrWrEn(ptrWrEn),
    .ptrWrData(ptrWrData),
    .ptrData(ptrData)
  );

  assign pcPlusOne = pc_q + PC_WIDTH'(1);
  assign pcBranch = pc_q + {{(PC_WIDTH-7){progWord[9]}}, progWord[9:3]} + PC_WIDTH'(1);
  assign wrFire = awready_q && s_axi_awvalid && wready_q && s_axi_wvalid;
  assign rdFire = arready_q && s_axi_arvalid;
  assign wrMapped = s_axi_awaddr[7] || (s_axi_awaddr[7:4] == 4'h0);
  assign rdMapped = s_axi_araddr[7] || (s_axi_araddr[7:4] == 4'h0);

  // ****************************************
  // execution sequencer, next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    dataAddr_d = dataAddr_q;
    dataRdEn_d = 1'b0;
    loadDst_d = loadDst_q;
    unsupported_d = unsupported_q;
    rfWrEn = 1'b0;
    rfWrAddr = progWord[8:4];
    rfWrData = operandData;
    ptrWrEn = 1'b0;
    ptrWrData = ptrData;
    unique case (state_q)
      ST_RUN: begin
        if (run_q) begin
          pc_d = pcPlusOne; // false condition falls through in one cycle [RL17]
          unsupported_d = 1'b0;
          if (isSkip) begin
            if (skipTaken) begin
              state_d = ST_SKIP2; // [RL1] [RL2] [RL3]
            end
          end else if (isBranch) begin
            if (branchTaken) begin
              pc_d = pcBranch; // [RL4] [RL5] [RL6] [RL7] [RL8] [RL9] [RL10] [RL11] [RL12]
              state_d = ST_BRANCH2; // [RL13] [RL17]
            end
          end else if (isCopy) begin
            rfWrEn = 1'b1; // [RL14]
          end else if (isLoadConst) begin
            rfWrEn = 1'b1; // [RL14]
            rfWrAddr = {1'b1, progWord[7:4]};
            rfWrData = {progWord[11:8], progWord[3:0]};
          end else if (isLoad) begin
            dataRdEn_d = 1'b1;
            loadDst_d = progWord[8:4];
            dataAddr_d = isLoadXDec ? ptrData - 16'h0001 : ptrData; // [RL15] [RL16]
            ptrWrEn = isLoadXInc || isLoadXDec;
            ptrWrData = isLoadXDec ? ptrData - 16'h0001 : ptrData + 16'h0001; // [RL15] [RL16]
            state_d = ST_LOAD2;
          end else begin
            unsupported_d = 1'b1; // other opcodes pass as one-cycle no-ops
          end
        end else begin
          // stopped: the bus may load the counter and the registers
          if (wrFire && s_axi_awaddr == exec_pkg::OFS_PC) begin
            if (s_axi_wstrb[0]) begin
              pc_d[7:0] = s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
              pc_d[PC_WIDTH-1:8] = s_axi_wdata[PC_WIDTH-1:8];
            end
          end
          if (wrFire && s_axi_awaddr[7] && s_axi_wstrb[0]) begin
            rfWrEn = 1'b1;
            rfWrAddr = s_axi_awaddr[6:2];
            rfWrData = s_axi_wdata[7:0];
          end
        end
      end
      ST_BRANCH2: begin
        state_d = ST_RUN; // second cycle of a taken branch [RL17]
      end
      ST_SKIP2: begin
        // pc already points at the skipped word, step over one or two words
        pc_d = isLongWord ? pc_q + PC_WIDTH'(2) : pcPlusOne; // [RL1] [RL17]
        state_d = ST_RUN;
      end
      ST_LOAD2: begin
        rfWrEn = 1'b1; // [RL15] [RL16]
        rfWrAddr = loadDst_q;
        rfWrData = dataRdData;
        state_d = ST_RUN;
      end
    endcase
  end

  // ****************************************
  // execution sequencer, registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_RUN;
      pc_q <= PC_WIDTH'(exec_pkg::PC_RESET);
      dataAddr_q <= 16'h0000;
      dataRdEn_q <= 1'b0;
      loadDst_q <= 5'h00;
      unsupported_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      dataAddr_q <= dataAddr_d;
      dataRdEn_q <= dataRdEn_d;
      loadDst_q <= loadDst_d;
      unsupported_q <= unsupported_d;
    end
  end

  // ****************************************
  // bus slave, next state
  // ****************************************
  always_comb begin
    run_d = run_q;
    flags_d = flags_q; // no instruction here changes a flag
    awready_d = 1'b0;
    wready_d = 1'b0;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    arready_d = 1'b0;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    // take address and data together, one cycle after both are offered
    if (s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q) begin
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (wrFire) begin
      bvalid_d = 1'b1;
      bresp_d = wrMapped ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
      if (s_axi_awaddr == exec_pkg::OFS_CTRL && s_axi_wstrb[0]) begin
        run_d = s_axi_wdata[exec_pkg::CTRL_RUN_BIT];
      end
      if (s_axi_awaddr == exec_pkg::OFS_FLAGS && s_axi_wstrb[0]) begin
        flags_d = s_axi_wdata[7:0];
      end
    end
    if (s_axi_arvalid && !arready_q && !rvalid_q) begin
      arready_d = 1'b1;
    end
    if (rdFire) begin
      rvalid_d = 1'b1;
      rresp_d = rdMapped ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr[7]) begin
        rdata_d[7:0] = debugData;
      end else if (s_axi_araddr == exec_pkg::OFS_CTRL) begin
        rdata_d[exec_pkg::CTRL_RUN_BIT] = run_q;
      end else if (s_axi_araddr == exec_pkg::OFS_PC) begin
        rdata_d[PC_WIDTH-1:0] = pc_q;
      end else if (s_axi_araddr == exec_pkg::OFS_FLAGS) begin
        rdata_d[7:0] = flags_q;
      end else if (s_axi_araddr == exec_pkg::OFS_STATUS) begin
        rdata_d[exec_pkg::STATUS_BUSY_BIT] = state_q != ST_RUN;
        rdata_d[exec_pkg::STATUS_UNSUPPORTED_BIT] = unsupported_q;
      end
    end
  end

  // ****************************************
  // bus slave, registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_q <= exec_pkg::CTRL_RUN_RESET;
      flags_q <= exec_pkg::FLAGS_RESET;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= exec_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= exec_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      run_q <= run_d;
      flags_q <= flags_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // outputs, all from flops
  // ****************************************
  assign progAddr = pc_q;
  assign dataAddr = dataAddr_q;
  assign dataRdEn = dataRdEn_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule

// ==== branch_exec_props.sv ====
// checker for jumps, loads and bus handshakes of the execution block
`timescale 1ns/10ps
module branch_exec_props #(
  parameter int unsigned PC_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [PC_WIDTH-1:0] progAddr,
  input wire logic [15:0] progWord,
  input wire logic dataRdEn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // helper state: last word, last pc, last bus take
  // ****************************************
  logic [15:0] prevWord_q;
  logic [PC_WIDTH-1:0] prevPc_q;
  logic prevAw_q;
  logic isBranch;
  logic isLong;
  logic isLoadX;
  logic [PC_WIDTH-1:0] target;

  // capture what was executed in the cycle before
  always_ff @(posedge core_clk) begin
    prevWord_q <= progWord;
    prevPc_q <= progAddr;
    prevAw_q <= s_axi_awready;
  end

  // decode of the previous word
  assign isBranch = (prevWord_q & exec_pkg::MASK_BRANCH) == exec_pkg::PAT_BRANCH;
  assign isLong = ((prevWord_q & exec_pkg::MASK_LONG_DIRECT) == exec_pkg::PAT_LONG_DIRECT) ||
                  ((prevWord_q & exec_pkg::MASK_LONG_JUMP) == exec_pkg::PAT_LONG_JUMP);
  assign isLoadX = (prevWord_q & exec_pkg::MASK_LOAD_X) inside
                   {exec_pkg::PAT_LOAD_X, exec_pkg::PAT_LOAD_X_INC, exec_pkg::PAT_LOAD_X_DEC};
  assign target = prevPc_q + PC_WIDTH'($signed(prevWord_q[9:3])) + 1'b1;

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // pc moved other than by one step, not after reset or a bus write
  sequence s_jump;
    !$past(reset) && !prevAw_q && progAddr != prevPc_q && progAddr != prevPc_q + 1'b1;
  endsequence
  sequence s_branch_jump;
    s_jump ##0 isBranch;
  endsequence

  a_jump_cause: assert property (s_jump |-> (isBranch && progAddr == target) ||
    (isLong && progAddr == prevPc_q + 2'd2)) else $error("pc jump without cause");
  a_branch_bubble: assert property (s_branch_jump |=> $stable(progAddr))
    else $error("taken branch without bubble");
  a_load_cause: assert property (dataRdEn |-> isLoadX)
    else $error("data read without load word");
  a_load_pulse: assert property (dataRdEn |=> !dataRdEn)
    else $error("data read longer than one cycle");
  a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
    else $error("address and data taken apart");
  a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");
  a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stays");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read data missing");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data stays");
  a_reset_idle: assert property (disable iff (1'b0) reset |=> !s_axi_bvalid && !s_axi_rvalid
    && !dataRdEn && progAddr == '0) else $error("outputs busy in reset");
endmodule

bind branch_skip_and_load_exec branch_exec_props #(.PC_WIDTH(PC_WIDTH)) props_i (
  .core_clk, .reset, .progAddr, .progWord, .dataRdEn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// ==== tb_top.sv ====
// self-checking bench for the branch, skip and load execution block
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] progAddr;
  logic [15:0] progWord;
  logic [255:0] ioRegs = {232'h0, 8'h20, 16'h0};
  logic [15:0] dataAddr;
  logic dataRdEn;
  logic [7:0] dataRdData;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [7:0] s_axi_araddr = 8'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  logic [15:0] pmem [64];
  logic [7:0] fl [3] = '{8'h55, 8'haa, 8'h00};
  logic [15:0] sw [6] = '{16'hfe53, 16'hfe52, 16'h9915, 16'h9914, 16'h9b15, 16'h9b14};
  logic [5:0] skTaken = 6'h19;
  logic [31:0] got;
  logic [31:0] expv;
  logic bitV;
  int n_errors = 0;
  int checks_done = 0;
  int i;
  int s;
  int c;

  // clock, program memory and data memory
  always #25 core_clk = ~core_clk;
  assign progWord = pmem[progAddr[5:0]];
  assign dataRdData = dataAddr[7:0] ^ 8'h5a;

  branch_skip_and_load_exec branch_skip_and_load_exec_i (
    .core_clk, .reset, .progAddr, .progWord, .ioRegs, .dataAddr, .dataRdEn, .dataRdData,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // ****************************************
  // compare, report and bus tasks
  // ****************************************
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check_data(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: resp %h expected %h", $time, g, e);
    end
  endtask

  task automatic expired();
    n_errors++;
    $display("timeout at %0t", $time);
    summarize();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) expired();
    check_resp(s_axi_bresp, er);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 100) expired();
    d = s_axi_rdata;
    check_resp(s_axi_rresp, er);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, exec_pkg::RESP_OKAY);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] g;
    axi_read(a, g, exec_pkg::RESP_OKAY);
    check_data(g, e);
  endtask

  function automatic logic [7:0] ra(input logic [4:0] n);
    return {1'b1, n, 2'b00};
  endfunction

  // load flags and start pc, clear the marker registers
  task automatic prep(input logic [7:0] f, input logic [15:0] pc);
    wr(exec_pkg::OFS_FLAGS, {24'h0, f});
    wr(exec_pkg::OFS_PC, {16'h0, pc});
    wr(ra(5'd16), 32'h0);
    wr(ra(5'd17), 32'h0);
    wr(ra(5'd18), 32'h0);
  endtask

  // run until the parking loop is reached, then stop
  task automatic run_prog();
    int n;
    wr(exec_pkg::OFS_CTRL, 32'h0000_0001);
    for (n = 0; n < 200 && progWord !== 16'hf3f8; n++) @(posedge core_clk);
    if (n == 200) expired();
    wr(exec_pkg::OFS_CTRL, 32'h0000_0000);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    foreach (pmem[j]) pmem[j] = 16'h0;
    pmem[1] = 16'he101;
    pmem[2] = 16'hf3f8;
    pmem[3] = 16'hf7f0;
    pmem[4] = 16'he202;
    pmem[5] = 16'hf3f8;
    pmem[6] = 16'hf7f0;
    pmem[18:21] = '{16'he323, 16'he212, 16'hf3f8, 16'hf7f0};
    pmem[32:39] = '{16'hea05, 16'h2e30, 16'h904d, 16'h914d, 16'h915e, 16'h916c,
                    16'hf3f8, 16'hf7f0};
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rdc(exec_pkg::OFS_CTRL, 32'h0000_0000);
    rdc(exec_pkg::OFS_PC, 32'h0000_0000);
    rdc(exec_pkg::OFS_FLAGS, 32'h0000_0000);
    rdc(ra(5'd7), 32'h0000_0000);
    axi_read(8'h10, got, exec_pkg::RESP_SLVERR);
    check_data(got, 32'h0000_0000);
    axi_write(8'h10, 32'h0000_00ff, exec_pkg::RESP_SLVERR);
    // every flag branch form, each flag seen set and clear
    for (i = 0; i < 3; i++) begin
      for (s = 0; s < 8; s++) begin
        for (c = 0; c < 2; c++) begin
          pmem[0] <= 16'hf018 | 16'(c << 10) | 16'(s);
          bitV = (s == 4) ? fl[i][2] ^ fl[i][3] : fl[i][s];
          expv = (bitV ^ c[0]) ? 32'h0000_0022 : 32'h0000_0011;
          prep(fl[i], 16'h0);
          run_prog();
          rdc(ra(5'd16), expv);
          rdc(exec_pkg::OFS_FLAGS, {24'h0, fl[i]});
        end
      end
    end
    // skips over a short and over a long word
    wr(ra(5'd5), 32'h0000_0008);
    for (i = 0; i < 6; i++) begin
      for (c = 0; c < 2; c++) begin
        pmem[16] <= sw[i];
        pmem[17] <= c[0] ? 16'h9000 : 16'he101;
        prep(8'h00, 16'h0010);
        run_prog();
        expv = (!c[0] && !skTaken[i]) ? 32'h0000_0011 : 32'h0000_0000;
        rdc(ra(5'd16), expv);
        expv = (c[0] && skTaken[i]) ? 32'h0000_0000 : 32'h0000_0033;
        rdc(ra(5'd18), expv);
        rdc(ra(5'd17), 32'h0000_0022);
      end
    end
    // copy, constant load and the three pointer loads
    wr(ra(5'd26), 32'h0000_0010);
    wr(ra(5'd27), 32'h0000_0000);
    prep(8'h3c, 16'h0020);
    run_prog();
    rdc(ra(5'd16), 32'h0000_00a5);
    rdc(ra(5'd3), 32'h0000_00a5);
    rdc(ra(5'd4), 32'h0000_004a);
    rdc(ra(5'd20), 32'h0000_004b);
    rdc(ra(5'd21), 32'h0000_004b);
    rdc(ra(5'd22), 32'h0000_004b);
    rdc(ra(5'd26), 32'h0000_0011);
    rdc(ra(5'd27), 32'h0000_0000);
    rdc(exec_pkg::OFS_FLAGS, 32'h0000_003c);
    summarize();
  end
endmodule
